// file: rtl/eeec_edge_line.sv
`timescale 1ns/10ps
module eeec_edge_line (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  eeec_line_if.line lif
);
  logic rise_tgl_reg;
  logic fall_tgl_reg;
  logic [2:0] rise_sync_reg;
  logic [2:0] fall_sync_reg;
  logic rise_seen;
  logic fall_seen;

  ////////////////////////////////////////////////////////////////////////////
  // toggles clocked by the line itself, so pulses shorter than a bus clock
  // period still leave a mark; a toggle needs no clear from the bus side
  always_ff @(posedge lif.line_in or negedge resetn_i) begin
    if (!resetn_i) begin
      rise_tgl_reg <= eeec_pkg::TGL_RST;
    end else begin
      rise_tgl_reg <= ~rise_tgl_reg;
    end
  end

  // falling edge catcher, same scheme
  always_ff @(negedge lif.line_in or negedge resetn_i) begin
    if (!resetn_i) begin
      fall_tgl_reg <= eeec_pkg::TGL_RST;
    end else begin
      fall_tgl_reg <= ~fall_tgl_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // three-stage crossing; stage 0 is read only by stage 1
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rise_sync_reg <= eeec_pkg::SYNC_RST;
      fall_sync_reg <= eeec_pkg::SYNC_RST;
    end else if (clk_en_i) begin
      rise_sync_reg <= {rise_sync_reg[1:0], rise_tgl_reg};
      fall_sync_reg <= {fall_sync_reg[1:0], fall_tgl_reg};
    end
  end

  // a change counts once stages one and two disagree
  assign rise_seen = rise_sync_reg[1] ^ rise_sync_reg[2];
  assign fall_seen = fall_sync_reg[1] ^ fall_sync_reg[2];
  // trigger choice is applied here, on the clean side of the crossing
  assign lif.edge_pulse = clk_en_i & ((lif.rise_en & rise_seen) | (lif.fall_en & fall_seen));

  ////////////////////////////////////////////////////////////////////////////
  property p_rise_only;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (clk_en_i && rise_seen && !fall_seen && !lif.rise_en) |-> !lif.edge_pulse;
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("disabled rising edge produced a pulse");

  property p_fall_pulse;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (clk_en_i && lif.fall_en && $changed(fall_sync_reg[1])) |-> fall_seen;
  endproperty
  a_fall_pulse: assert property (p_fall_pulse) else $error("falling edge lost in crossing");
endmodule

// file: rtl/eeec_line_if.sv
`timescale 1ns/10ps
// one line between the routing/status logic and its edge catcher
interface eeec_line_if;
  logic line_in;
  logic rise_en;
  logic fall_en;
  logic edge_pulse;
  modport ctrl (output line_in, output rise_en, output fall_en, input edge_pulse);
  modport line (input line_in, input rise_en, input fall_en, output edge_pulse);
endinterface

// file: rtl/eeec_pkg.sv
package eeec_pkg;
  // line counts and routing geometry
  localparam int NUM_LINES = 19;
  localparam int NUM_GPIO = 112;
  localparam int NUM_PIN_LINES = 16;
  localparam int NUM_PORTS = 7;
  localparam int SEL_W = 3;
  localparam int NUM_AUX = NUM_LINES - NUM_PIN_LINES;
  // field position of a line's port select inside the packed select bus
  localparam int SEL_POS_STEP = SEL_W;
  // synchroniser depth for the captured toggles
  localparam int SYNC_STAGES = 3;
  // reset values
  localparam logic [18:0] PEND_RST = 19'h0_0000;
  localparam logic [18:0] EVT_RST = 19'h0_0000;
  localparam logic [2:0] SYNC_RST = 3'h0;
  localparam logic TGL_RST = 1'b0;
  // cycles from a sampled pin change to the edge pulse
  localparam int EDGE_LATENCY = 1;
endpackage

// file: rtl/eeec_top.sv
`timescale 1ns/10ps
// Summary of operation
// - nineteen lines, each with own edge detector
// - per line trigger: rising, falling or both
// - per line mask blocks only that line
// - pending bit per line, readable by software
// - edges shorter than clock period still caught
// - 112 pins routed onto sixteen lines
module eeec_top (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic [111:0] gpio_pin_i,
  input wire logic [2:0] aux_event_i,
  input wire logic [47:0] port_sel_i,
  input wire logic [18:0] rise_en_i,
  input wire logic [18:0] fall_en_i,
  input wire logic [18:0] irq_unmask_i,
  input wire logic [18:0] evt_unmask_i,
  input wire logic [18:0] pend_clr_i,
  output logic [18:0] pending_o,
  output logic [18:0] irq_o,
  output logic [18:0] event_o
);
  logic [18:0] pend_reg;
  logic [18:0] pend_next;
  logic [18:0] evt_reg;
  logic [18:0] edge_vec;
  // line levels after routing, watched only by the checks below
  logic [18:0] line_vec;

  eeec_line_if lif [eeec_pkg::NUM_LINES] ();

  ////////////////////////////////////////////////////////////////////////////
  // routing and one edge catcher per line
  genvar gi;
  generate
    for (gi = 0; gi < eeec_pkg::NUM_LINES; gi++) begin : g_line
      if (gi < eeec_pkg::NUM_PIN_LINES) begin : g_pin
        logic [2:0] sel;
        logic sel_ok;
        logic routed;
        assign sel = port_sel_i[gi * eeec_pkg::SEL_POS_STEP +: eeec_pkg::SEL_W];
        assign sel_ok = (int'(sel) < eeec_pkg::NUM_PORTS);
        // line k of port p is pin p*16+k; an unused code parks the line low
        always_comb begin
          routed = 1'b0;
          if (sel_ok) begin
            routed = gpio_pin_i[int'(sel) * eeec_pkg::NUM_PIN_LINES + gi];
          end
        end
        assign lif[gi].line_in = routed;

        // a parked code must keep the line quiet, or a stray pin could fire it
        // and set a pending bit that software never asked for
        property p_route_hold;
          @(posedge clk_sys_i) disable iff (!resetn_i)
          !sel_ok |-> !lif[gi].line_in;
        endproperty
        a_route_hold: assert property (p_route_hold) else $error("unused port code drives a line");
      end else begin : g_aux
        // the last lines come from internal event sources, not from pins
        assign lif[gi].line_in = aux_event_i[gi - eeec_pkg::NUM_PIN_LINES];
      end
      assign lif[gi].rise_en = rise_en_i[gi];
      assign lif[gi].fall_en = fall_en_i[gi];
      assign edge_vec[gi] = lif[gi].edge_pulse;
      assign line_vec[gi] = lif[gi].line_in;

      // one catcher per line; aux lines use the same scheme as pins
      eeec_edge_line u_edge (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .clk_en_i(clk_en_i),
        .lif(lif[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // pending: a detected edge beats a clear in the same cycle
  always_comb begin
    pend_next = (pend_reg & ~pend_clr_i) | edge_vec;
  end

  // frozen enable keeps the bit; a clear strobe waits for enable as well
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pend_reg <= eeec_pkg::PEND_RST;
    end else if (clk_en_i) begin
      pend_reg <= pend_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event request: one-cycle pulse, independent of the pending state
  // it needs no clear, but a line toggling every cycle with both triggers on pulses every cycle
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      evt_reg <= eeec_pkg::EVT_RST;
    end else if (clk_en_i) begin
      evt_reg <= edge_vec & evt_unmask_i;
    end
  end

  assign pending_o = pend_reg;
  // level request; masking only gates the output, pending still records
  assign irq_o = pend_reg & irq_unmask_i;
  assign event_o = evt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // all checks below run on the bus clock; reset silences all of them except the reset check
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  // some enabled line produced an edge in this cycle
  sequence s_edge_taken;
    clk_en_i && (edge_vec != 19'h0_0000);
  endsequence

  // a level change the bus clock can see, with its trigger held on
  sequence s_line_rise(int k);
    $rose(line_vec[k]) && rise_en_i[k] && clk_en_i ##1 clk_en_i && rise_en_i[k] ##1 clk_en_i && rise_en_i[k];
  endsequence

  // the falling twin; a glitch that spans no clock edge never starts either
  sequence s_line_fall(int k);
    $fell(line_vec[k]) && fall_en_i[k] && clk_en_i ##1 clk_en_i && fall_en_i[k] ##1 clk_en_i && fall_en_i[k];
  endsequence

  // an edge always lands in pending, masked or not
  property p_pend_set;
    s_edge_taken |=> ((pending_o & $past(edge_vec)) == $past(edge_vec));
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("edge did not set pending");

  // a strobe with no competing edge empties the bit
  property p_pend_clear;
    clk_en_i |=> ((pending_o & $past(pend_clr_i & ~edge_vec)) == 19'h0_0000);
  endproperty
  a_pend_clear: assert property (p_pend_clear) else $error("write one did not clear pending");

  // nothing sets pending but an edge
  property p_pend_cause;
    clk_en_i |=> ((pending_o & ~$past(pending_o) & ~$past(edge_vec)) == 19'h0_0000);
  endproperty
  a_pend_cause: assert property (p_pend_cause) else $error("pending set without an edge");

  // a pending bit only falls on a clear strobe
  property p_pend_hold;
    clk_en_i |=> ((pending_o & $past(pending_o & ~pend_clr_i)) == $past(pending_o & ~pend_clr_i));
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pending bit lost without a clear");

  // low enable holds the pending and event registers where they are
  property p_freeze;
    !clk_en_i |=> ($stable(pending_o) && $stable(event_o));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");

  // edges wait in the crossing while the enable is low
  property p_edge_frozen;
    !clk_en_i |-> (edge_vec == 19'h0_0000);
  endproperty
  a_edge_frozen: assert property (p_edge_frozen) else $error("edge pulse while clock enable low");

  // event is a one-cycle copy of the unmasked edges
  property p_evt_mask;
    clk_en_i |=> (event_o == ($past(edge_vec) & $past(evt_unmask_i)));
  endproperty
  a_evt_mask: assert property (p_evt_mask) else $error("event pulse disagrees with mask");

  // masked lines never reach the interrupt output
  property p_irq_mask;
    (irq_o & ~irq_unmask_i) == 19'h0_0000;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked line raised an interrupt");

  // an unmasked edge raises its interrupt on the next cycle
  property p_irq_follow;
    (s_edge_taken ##0 ((edge_vec & irq_unmask_i) != 19'h0_0000)) ##1 $stable(irq_unmask_i)
      |-> ((irq_o & $past(edge_vec & irq_unmask_i)) == $past(edge_vec & irq_unmask_i));
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("unmasked edge raised no interrupt");

  // async reset empties the state without waiting for a clock
  property p_rst_clean;
    disable iff (1'b0) !resetn_i |-> ((pending_o == 19'h0_0000) && (event_o == 19'h0_0000));
  endproperty
  a_rst_clean: assert property (p_rst_clean) else $error("reset left pending or event state");

  // checks per line; each only looks at its own bits
  generate
    for (gi = 0; gi < eeec_pkg::NUM_LINES; gi++) begin : g_chk
      // a steady rise with its trigger on must show up as a pulse
      property p_line_rise;
        s_line_rise(gi) |-> ##[0:2] edge_vec[gi];
      endproperty
      a_line_rise: assert property (p_line_rise) else $error("rising edge on a line not detected");

      // a steady fall likewise
      property p_line_fall;
        s_line_fall(gi) |-> ##[0:2] edge_vec[gi];
      endproperty
      a_line_fall: assert property (p_line_fall) else $error("falling edge on a line not detected");

      // both triggers off keeps the line silent whatever the pin does
      property p_trig_off;
        (!rise_en_i[gi] && !fall_en_i[gi]) |-> !edge_vec[gi];
      endproperty
      a_trig_off: assert property (p_trig_off) else $error("line with no trigger produced a pulse");

      // a masked line's event stays low
      property p_evt_line;
        (clk_en_i && !evt_unmask_i[gi]) |=> !event_o[gi];
      endproperty
      a_evt_line: assert property (p_evt_line) else $error("masked line produced an event");
    end
  endgenerate
endmodule

// file: tb/eeec_pin_src.sv
`timescale 1ns/10ps
// far side: pin and aux sources, idle low between glitches
module eeec_pin_src (
  output logic [111:0] gpio_pin_o,
  output logic [2:0] aux_o
);
  initial begin
    gpio_pin_o = '0;
    aux_o = '0;
  end
  // one source to a level; indices past the pins reach the aux sources
  task automatic level(input int idx, input logic v);
    if (idx < 112) begin
      gpio_pin_o[idx] = v;
    end else begin
      aux_o[idx - 112] = v;
    end
  endtask
  // glitch narrower than a clock period, so only async capture sees it
  task automatic pulse(input int idx, input int w);
    level(idx, 1'h1);
    #(w);
    level(idx, 1'h0);
  endtask
endmodule

// file: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic clk_sys_i = 1'h0;
  logic resetn_i = 1'h1;
  logic en = 1'h1;
  logic [111:0] gpio;
  logic [2:0] aux;
  logic [47:0] sel = 48'hffff_ffff_ffff;
  logic [47:0] s_tmp;
  logic [18:0] rise = '0, fall = '0, imask = '1, emask = '1, clr = '0;
  logic [18:0] pend, irq, evt, exp;
  int fails = 0, num_checks = 0, evt_cnt = 0, e0;
  typedef struct {int line; int port; logic r; logic f;} eeec_row_t;
  // short glitch per row: line, port code, rise enable, fall enable
  eeec_row_t rows[6] = '{'{0, 0, 1, 0}, '{5, 3, 0, 1}, '{15, 6, 1, 1}, '{9, 2, 0, 0}, '{16, 0, 1, 0}, '{18, 0, 0, 1}};
  ////////////////////////////////////////////////////////////////
  always #2 clk_sys_i = ~clk_sys_i;
  // event pulses are one cycle, so count them as they pass
  always @(posedge clk_sys_i) evt_cnt <= evt_cnt + $countones(evt);
  eeec_pin_src pin_u (.gpio_pin_o(gpio), .aux_o(aux));
  eeec_top dut_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .clk_en_i(en), .gpio_pin_i(gpio),
    .aux_event_i(aux), .port_sel_i(sel), .rise_en_i(rise), .fall_en_i(fall), .irq_unmask_i(imask),
    .evt_unmask_i(emask), .pend_clr_i(clr), .pending_o(pend), .irq_o(irq), .event_o(evt));
  ////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [18:0] e, input logic [18:0] got);
    num_checks++;
    if (got !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, got);
    end
  endtask
  task automatic summarize();
    if (fails == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // glitch then wait out the sync path before looking
  task automatic fire(input int idx);
    @(posedge clk_sys_i);
    #1;
    pin_u.pulse(idx, 1);
    repeat (6) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic clear_all();
    @(posedge clk_sys_i);
    clr <= '1;
    @(posedge clk_sys_i);
    clr <= '0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    fails++;
    summarize();
  end
  initial begin
    // a real falling edge at time zero, so the pin-clocked toggles reset too
    resetn_i <= 1'h0;
    repeat (2) @(posedge clk_sys_i);
    resetn_i <= 1'h1;
    #1;
    check("pending_rst", '0, pend);
    check("irq_rst", '0, irq);
    // table rows: other pin lines parked on code 7, same trigger everywhere
    foreach (rows[i]) begin
      s_tmp = 48'hffff_ffff_ffff;
      if (rows[i].line < 16) s_tmp[3*rows[i].line +: 3] = rows[i].port[2:0];
      @(posedge clk_sys_i);
      sel <= s_tmp;
      rise <= rows[i].r ? 19'h7_ffff : 19'h0_0000;
      fall <= rows[i].f ? 19'h7_ffff : 19'h0_0000;
      fire(rows[i].line < 16 ? rows[i].port * 16 + rows[i].line : 96 + rows[i].line);
      exp = (rows[i].r | rows[i].f) ? (19'h0_0001 << rows[i].line) : 19'h0_0000;
      check("pending_row", exp, pend);
      check("irq_row", exp, irq);
      clear_all();
      check("pending_clr", '0, pend);
    end
    // masked line 4 still records but forwards nothing
    @(posedge clk_sys_i);
    sel <= 48'hffff_ffff_9fff;
    rise <= '1;
    fall <= '0;
    imask <= 19'h7_ffef;
    emask <= 19'h7_ffef;
    e0 = evt_cnt;
    fire(16 + 4);
    check("pending_masked", 19'h0_0010, pend);
    check("irq_masked", '0, irq);
    check("event_masked", '0, 19'(evt_cnt - e0));
    // unmask: level irq appears at once, clear takes it away
    @(posedge clk_sys_i);
    imask <= '1;
    emask <= '1;
    #1;
    check("irq_unmasked", 19'h0_0010, irq);
    clear_all();
    e0 = evt_cnt;
    fire(16 + 4);
    check("event_once", 19'h0_0001, 19'(evt_cnt - e0));
    clear_all();
    // level steps tell the triggers apart: line 1 rise only, line 0 fall only
    @(posedge clk_sys_i);
    sel <= 48'hffff_ffff_ffc0;
    rise <= 19'h0_0002;
    fall <= 19'h0_0001;
    #1;
    pin_u.level(0, 1'h1);
    pin_u.level(1, 1'h1);
    repeat (6) @(posedge clk_sys_i);
    #1;
    check("pending_rise_step", 19'h0_0002, pend);
    clear_all();
    pin_u.level(0, 1'h0);
    pin_u.level(1, 1'h0);
    repeat (6) @(posedge clk_sys_i);
    #1;
    check("pending_fall_step", 19'h0_0001, pend);
    clear_all();
    // frozen enable holds a caught glitch until it returns
    @(posedge clk_sys_i);
    en <= 1'h0;
    fire(0);
    check("pending_frozen", '0, pend);
    @(posedge clk_sys_i);
    en <= 1'h1;
    repeat (4) @(posedge clk_sys_i);
    #1;
    check("pending_thawed", 19'h0_0001, pend);
    // mid-run reset drops the pending bit; lines work again after release
    @(posedge clk_sys_i);
    resetn_i <= 1'h0;
    @(posedge clk_sys_i);
    #1;
    check("pending_reset", '0, pend);
    check("irq_reset", '0, irq);
    @(posedge clk_sys_i);
    resetn_i <= 1'h1;
    repeat (2) @(posedge clk_sys_i);
    #1;
    check("pending_after_reset", '0, pend);
    fire(0);
    check("pending_after_reset_edge", 19'h0_0001, pend);
    summarize();
  end
endmodule
